/* File: hw/bfw_pkg.sv */
/*
 * Constants and helpers of the bridge forwarding window registers: offsets, field layout,
 * reset values and the window expansion arithmetic.
 * Assumes configuration accesses arrive as dword indexes with byte enables.
 */
package bfw_pkg;

    localparam logic [7:0] OFS_MMIO_BASE = 8'h20;
    localparam logic [7:0] OFS_MMIO_LIMIT = 8'h22;
    localparam logic [7:0] OFS_PREF_BASE = 8'h24;
    localparam logic [7:0] OFS_PREF_LIMIT = 8'h26;
    localparam logic [7:0] OFS_PREF_BASE_HI = 8'h28;
    localparam logic [7:0] OFS_PREF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] OFS_IO_BASE_HI = 8'h30;

    localparam logic [5:0] DW_MMIO = OFS_MMIO_BASE[7:2];
    localparam logic [5:0] DW_PREF = OFS_PREF_BASE[7:2];
    localparam logic [5:0] DW_PREF_BASE_HI = OFS_PREF_BASE_HI[7:2];
    localparam logic [5:0] DW_PREF_LIMIT_HI = OFS_PREF_LIMIT_HI[7:2];
    localparam logic [5:0] DW_IO_HI = OFS_IO_BASE_HI[7:2];

    localparam int HIT_MMIO = 0;
    localparam int HIT_PREF = 1;
    localparam int HIT_PREF_BASE_HI = 2;
    localparam int HIT_PREF_LIMIT_HI = 3;
    localparam int HIT_IO_HI = 4;
    localparam int HIT_COUNT = 5;

    localparam int WIN_FIELD_LSB = 4;
    localparam int WIN_FIELD_MSB = 15;
    localparam int WIN_ADDR_LSB = 20;
    localparam logic [15:0] WIN_FIELD_MASK = 16'hfff0;
    localparam logic [19:0] WIN_LOW_ZEROS = 20'h00000;
    localparam logic [19:0] WIN_LOW_ONES = 20'hfffff;

    localparam logic [15:0] RST_MMIO_BASE = 16'h0000;
    localparam logic [15:0] RST_MMIO_LIMIT = 16'h0000;
    localparam logic [15:0] RST_PREF_BASE = 16'h0000;
    localparam logic [15:0] RST_PREF_LIMIT = 16'h0000;
    localparam logic [31:0] RST_PREF_BASE_HI = 32'h00000000;
    localparam logic [31:0] RST_PREF_LIMIT_HI = 32'h00000000;
    localparam logic [15:0] RST_IO_BASE_HI = 16'h0000;

    function automatic logic [63:0] win_base(input logic [15:0] r, input logic [31:0] hi);
        win_base = {hi, r[WIN_FIELD_MSB:WIN_FIELD_LSB], WIN_LOW_ZEROS};
    endfunction

    function automatic logic [63:0] win_limit(input logic [15:0] r, input logic [31:0] hi);
        win_limit = {hi, r[WIN_FIELD_MSB:WIN_FIELD_LSB], WIN_LOW_ONES};
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [15:0] mask);
        merge16 = (old & ~mask) | (nw & mask);
    endfunction

    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] mask);
        merge32 = (old & ~mask) | (nw & mask);
    endfunction

endpackage

/* File: hw/bfw_cfg_if.sv */
/*
 * Carrier between the register top and its configuration decoder.
 * Assumes both ends run on the configuration clock.
 */
`timescale 1ns/100ps
interface bfw_cfg_if;
    logic sel;
    logic wr;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [bfw_pkg::HIT_COUNT-1:0] dw_hit;
    logic [31:0] lane_mask;
    logic any_hit;

    modport decoder(input sel, wr, dw_addr, be, output dw_hit, lane_mask, any_hit);
    modport regs(output sel, wr, dw_addr, be, input dw_hit, lane_mask, any_hit);
endinterface

/* File: hw/bfw_cfg_decode.sv */
/*
 * Dword decoder of the forwarding window registers: one select per claimed dword and a bit
 * mask from the byte enables.
 * Assumes the top qualifies the result with its own clocked logic.
 */
`timescale 1ns/100ps
module bfw_cfg_decode (
    bfw_cfg_if.decoder cfg
);
    always_comb begin
        cfg.dw_hit = '0;
        if (cfg.sel) begin
            cfg.dw_hit[bfw_pkg::HIT_MMIO] = (cfg.dw_addr == bfw_pkg::DW_MMIO);
            cfg.dw_hit[bfw_pkg::HIT_PREF] = (cfg.dw_addr == bfw_pkg::DW_PREF);
            cfg.dw_hit[bfw_pkg::HIT_PREF_BASE_HI] = (cfg.dw_addr == bfw_pkg::DW_PREF_BASE_HI);
            cfg.dw_hit[bfw_pkg::HIT_PREF_LIMIT_HI] = (cfg.dw_addr == bfw_pkg::DW_PREF_LIMIT_HI);
            cfg.dw_hit[bfw_pkg::HIT_IO_HI] = (cfg.dw_addr == bfw_pkg::DW_IO_HI);
        end
        cfg.any_hit = |cfg.dw_hit;
        cfg.lane_mask = {{8{cfg.be[3]}}, {8{cfg.be[2]}}, {8{cfg.be[1]}}, {8{cfg.be[0]}}};
    end
endmodule // bfw_cfg_decode

/* File: hw/bfw_win_match.sv */
/*
 * Inclusive range check of one forwarding window.
 * Assumes base and limit are already expanded to full byte addresses.
 */
`timescale 1ns/100ps
module bfw_win_match (
    input wire logic [63:0] addr_in,
    input wire logic [63:0] base_in,
    input wire logic [63:0] limit_in,
    output logic hit_out
);
    // An empty window is one whose limit lies below its base; it then matches nothing.
    always_comb begin
        hit_out = (addr_in >= base_in) && (addr_in <= limit_in);
    end
endmodule // bfw_win_match

/* File: hw/bfw_top.sv */
/*
 * Forwarding window registers of a two-interface bus bridge and the decisions they steer.
 * Assumes configuration requests and forwarding queries come from logic on clk_in, and that
 * the lower I/O window bits and the I/O limit come from neighbouring registers.
 */
// Function
// - The memory base sets the lowest address of the memory-mapped I/O forwarding window.
// - Bits 15 to 4 of each memory and prefetchable base or limit are writable address bits 31:20.
// - A window base has address bits 19 to 0 taken as zero.
// - A window limit has address bits 19 to 0 taken as ones.
// - Bits 3 to 0 of those four registers ignore writes and read as zero.
// - The memory limit sets the highest address of the memory-mapped I/O window.
// - A separate prefetchable window with its own base also decides memory forwarding.
// - The prefetchable base upper word supplies base address bits 63 to 32.
// - The prefetchable limit upper word supplies limit address bits 63 to 32.
// - The I/O base upper half is fully writable and supplies I/O base bits 31 to 16.
// - The I/O window governs I/O transactions passed from the primary to the secondary bus.
`timescale 1ns/100ps
module bfw_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cfg_sel_in,
    input wire logic cfg_wr_in,
    input wire logic [5:0] cfg_dw_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_ack_out,
    output logic cfg_hit_out,
    input wire logic [15:0] io_base_low_in,
    input wire logic [31:0] io_limit_in,
    input wire logic fwd_req_in,
    input wire logic [63:0] fwd_addr_in,
    input wire logic fwd_is_io_in,
    input wire logic fwd_from_primary_in,
    output logic fwd_valid_out,
    output logic fwd_mmio_hit_out,
    output logic fwd_pref_hit_out,
    output logic fwd_io_hit_out,
    output logic fwd_cross_out
);
    bfw_cfg_if cfg();

    logic [15:0] mmio_window_base;
    logic [15:0] mmio_window_limit;
    logic [15:0] prefetch_window_base;
    logic [15:0] prefetch_window_limit;
    logic [31:0] prefetch_base_high_word;
    logic [31:0] prefetch_limit_high_word;
    logic [15:0] io_window_base_high_half;
    logic [15:0] next_mmio_window_base;
    logic [15:0] next_mmio_window_limit;
    logic [15:0] next_prefetch_window_base;
    logic [15:0] next_prefetch_window_limit;
    logic [31:0] next_prefetch_base_high_word;
    logic [31:0] next_prefetch_limit_high_word;
    logic [15:0] next_io_window_base_high_half;
    logic [31:0] next_cfg_rdata;
    logic next_cfg_ack;
    logic next_cfg_hit;
    logic wr_en;
    logic [31:0] win_mask;

    logic [63:0] mmio_lo;
    logic [63:0] mmio_hi;
    logic [63:0] pref_lo;
    logic [63:0] pref_hi;
    logic [63:0] io_lo;
    logic [63:0] io_hi;
    logic mmio_match;
    logic pref_match;
    logic io_match;
    logic next_fwd_valid;
    logic next_fwd_mmio_hit;
    logic next_fwd_pref_hit;
    logic next_fwd_io_hit;
    logic next_fwd_cross;

    assign cfg.sel = cfg_sel_in;
    assign cfg.wr = cfg_wr_in;
    assign cfg.dw_addr = cfg_dw_addr_in;
    assign cfg.be = cfg_be_in;

    bfw_cfg_decode u_decode (
        .cfg(cfg.decoder)
    );

    // Register writes. The four base and limit registers merge only their window field lanes, so their bits 3:0 stay zero.
    always_comb begin
        wr_en = cfg_wr_in && cfg.any_hit;
        win_mask = cfg.lane_mask & {bfw_pkg::WIN_FIELD_MASK, bfw_pkg::WIN_FIELD_MASK};
        next_mmio_window_base = mmio_window_base;
        next_mmio_window_limit = mmio_window_limit;
        next_prefetch_window_base = prefetch_window_base;
        next_prefetch_window_limit = prefetch_window_limit;
        next_prefetch_base_high_word = prefetch_base_high_word;
        next_prefetch_limit_high_word = prefetch_limit_high_word;
        next_io_window_base_high_half = io_window_base_high_half;
        if (wr_en && cfg.dw_hit[bfw_pkg::HIT_MMIO]) begin
            next_mmio_window_base = bfw_pkg::merge16(mmio_window_base, cfg_wdata_in[15:0],
                                                     win_mask[15:0]);
            next_mmio_window_limit = bfw_pkg::merge16(mmio_window_limit, cfg_wdata_in[31:16],
                                                      win_mask[31:16]);
        end
        if (wr_en && cfg.dw_hit[bfw_pkg::HIT_PREF]) begin
            next_prefetch_window_base = bfw_pkg::merge16(prefetch_window_base,
                                                         cfg_wdata_in[15:0],
                                                         win_mask[15:0]);
            next_prefetch_window_limit = bfw_pkg::merge16(prefetch_window_limit,
                                                          cfg_wdata_in[31:16],
                                                          win_mask[31:16]);
        end
        if (wr_en && cfg.dw_hit[bfw_pkg::HIT_PREF_BASE_HI]) begin
            next_prefetch_base_high_word = bfw_pkg::merge32(prefetch_base_high_word,
                                                            cfg_wdata_in,
                                                            cfg.lane_mask);
        end
        if (wr_en && cfg.dw_hit[bfw_pkg::HIT_PREF_LIMIT_HI]) begin
            next_prefetch_limit_high_word = bfw_pkg::merge32(prefetch_limit_high_word,
                                                             cfg_wdata_in,
                                                             cfg.lane_mask);
        end
        if (wr_en && cfg.dw_hit[bfw_pkg::HIT_IO_HI]) begin
            next_io_window_base_high_half = bfw_pkg::merge16(io_window_base_high_half,
                                                             cfg_wdata_in[15:0],
                                                             cfg.lane_mask[15:0]);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mmio_window_base <= bfw_pkg::RST_MMIO_BASE;
            mmio_window_limit <= bfw_pkg::RST_MMIO_LIMIT;
            prefetch_window_base <= bfw_pkg::RST_PREF_BASE;
            prefetch_window_limit <= bfw_pkg::RST_PREF_LIMIT;
            prefetch_base_high_word <= bfw_pkg::RST_PREF_BASE_HI;
            prefetch_limit_high_word <= bfw_pkg::RST_PREF_LIMIT_HI;
            io_window_base_high_half <= bfw_pkg::RST_IO_BASE_HI;
        end else begin
            mmio_window_base <= next_mmio_window_base;
            mmio_window_limit <= next_mmio_window_limit;
            prefetch_window_base <= next_prefetch_window_base;
            prefetch_window_limit <= next_prefetch_window_limit;
            prefetch_base_high_word <= next_prefetch_base_high_word;
            prefetch_limit_high_word <= next_prefetch_limit_high_word;
            io_window_base_high_half <= next_io_window_base_high_half;
        end
    end

    // Read answer. Unclaimed dwords answer zero so that a larger configuration space can OR
    // several blocks together; the upper half at the I/O dword belongs to another block.
    always_comb begin
        next_cfg_ack = cfg_sel_in;
        next_cfg_hit = cfg.any_hit;
        next_cfg_rdata = 32'h00000000;
        if (cfg_sel_in && !cfg_wr_in) begin
            unique case (1'b1)
                cfg.dw_hit[bfw_pkg::HIT_MMIO]:
                    next_cfg_rdata = {mmio_window_limit, mmio_window_base};
                cfg.dw_hit[bfw_pkg::HIT_PREF]:
                    next_cfg_rdata = {prefetch_window_limit, prefetch_window_base};
                cfg.dw_hit[bfw_pkg::HIT_PREF_BASE_HI]:
                    next_cfg_rdata = prefetch_base_high_word;
                cfg.dw_hit[bfw_pkg::HIT_PREF_LIMIT_HI]:
                    next_cfg_rdata = prefetch_limit_high_word;
                cfg.dw_hit[bfw_pkg::HIT_IO_HI]:
                    next_cfg_rdata = {16'h0000, io_window_base_high_half};
                default:
                    next_cfg_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 32'h00000000;
            cfg_ack_out <= 1'b0;
            cfg_hit_out <= 1'b0;
        end else begin
            cfg_rdata_out <= next_cfg_rdata;
            cfg_ack_out <= next_cfg_ack;
            cfg_hit_out <= next_cfg_hit;
        end
    end

    // Window expansion. The memory-mapped I/O window is 32-bit, so its upper word is zero.
    // The prefetchable window compares all 64 bits; with 32-bit addressing it relies on
    // software having cleared both upper words.
    always_comb begin
        mmio_lo = bfw_pkg::win_base(mmio_window_base, 32'h00000000);
        mmio_hi = bfw_pkg::win_limit(mmio_window_limit, 32'h00000000);
        pref_lo = bfw_pkg::win_base(prefetch_window_base, prefetch_base_high_word);
        pref_hi = bfw_pkg::win_limit(prefetch_window_limit, prefetch_limit_high_word);
        io_lo = {32'h00000000, io_window_base_high_half, io_base_low_in};
        io_hi = {32'h00000000, io_limit_in};
    end

    bfw_win_match u_mmio_match (
        .addr_in(fwd_addr_in),
        .base_in(mmio_lo),
        .limit_in(mmio_hi),
        .hit_out(mmio_match)
    );

    bfw_win_match u_pref_match (
        .addr_in(fwd_addr_in),
        .base_in(pref_lo),
        .limit_in(pref_hi),
        .hit_out(pref_match)
    );

    bfw_win_match u_io_match (
        .addr_in(fwd_addr_in),
        .base_in(io_lo),
        .limit_in(io_hi),
        .hit_out(io_match)
    );

    // Forwarding decision, answered one cycle after the query.
    always_comb begin
        next_fwd_valid = fwd_req_in;
        next_fwd_mmio_hit = fwd_req_in && !fwd_is_io_in && mmio_match;
        next_fwd_pref_hit = fwd_req_in && !fwd_is_io_in && pref_match;
        next_fwd_io_hit = fwd_req_in && fwd_is_io_in && fwd_from_primary_in && io_match;
        next_fwd_cross = next_fwd_mmio_hit || next_fwd_pref_hit || next_fwd_io_hit;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fwd_valid_out <= 1'b0;
            fwd_mmio_hit_out <= 1'b0;
            fwd_pref_hit_out <= 1'b0;
            fwd_io_hit_out <= 1'b0;
            fwd_cross_out <= 1'b0;
        end else begin
            fwd_valid_out <= next_fwd_valid;
            fwd_mmio_hit_out <= next_fwd_mmio_hit;
            fwd_pref_hit_out <= next_fwd_pref_hit;
            fwd_io_hit_out <= next_fwd_io_hit;
            fwd_cross_out <= next_fwd_cross;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_full_write(logic [5:0] dw);
        cfg_sel_in && cfg_wr_in && (cfg_be_in == 4'hf) && (cfg_dw_addr_in == dw);
    endsequence

    sequence s_read(logic [5:0] dw);
        cfg_sel_in && !cfg_wr_in && (cfg_dw_addr_in == dw);
    endsequence

    sequence s_mem_query;
        fwd_req_in && !fwd_is_io_in;
    endsequence

    AST_FIELD_WRITE: assert property (
        s_full_write(bfw_pkg::DW_MMIO) ##1 1'b1 |->
        mmio_window_base == {$past(cfg_wdata_in[15:4]), 4'h0})
        else $error("memory base field did not take the written bits 15 to 4");

    AST_LOW_READ_ZERO: assert property (
        s_read(bfw_pkg::DW_PREF) |=>
        cfg_ack_out && cfg_rdata_out[3:0] == 4'h0 && cfg_rdata_out[19:16] == 4'h0)
        else $error("low four bits of a window register read back nonzero");

    AST_BASE_ALIGN: assert property (
        s_mem_query ##0 (fwd_addr_in == mmio_lo - 64'h1) ##0 (mmio_lo != 64'h0) |=>
        !fwd_mmio_hit_out)
        else $error("address just below the memory base was forwarded");

    AST_MMIO_BASE_HIT: assert property (
        s_mem_query ##0 (fwd_addr_in == mmio_lo) ##0 (mmio_lo <= mmio_hi) |=>
        fwd_mmio_hit_out && fwd_cross_out)
        else $error("memory base address was not forwarded");

    AST_LIMIT_ONES: assert property (
        s_mem_query ##0 (fwd_addr_in == {32'h0, mmio_window_limit[15:4], 20'hfffff}) ##0
        (mmio_lo <= mmio_hi) |=> fwd_mmio_hit_out)
        else $error("last byte of the limit block was not forwarded");

    AST_MMIO_ABOVE_LIMIT: assert property (
        s_mem_query ##0 (fwd_addr_in == mmio_hi + 64'h1) |=> !fwd_mmio_hit_out)
        else $error("address above the memory limit was forwarded");

    AST_PREF_INSIDE: assert property (
        s_mem_query ##0 (fwd_addr_in >= pref_lo && fwd_addr_in <= pref_hi) |=>
        fwd_pref_hit_out && fwd_valid_out)
        else $error("address inside the prefetchable window was not forwarded");

    // The read follows the write after one idle cycle, the spacing that software uses here.
    AST_PREF_BASE_HI: assert property (
        s_full_write(bfw_pkg::DW_PREF_BASE_HI) ##1 !cfg_sel_in ##1
        s_read(bfw_pkg::DW_PREF_BASE_HI) |=> cfg_rdata_out == $past(cfg_wdata_in, 3))
        else $error("prefetchable base upper word did not read back as written");

    AST_PREF_LIMIT_HI: assert property (
        s_full_write(bfw_pkg::DW_PREF_LIMIT_HI) |=> pref_hi[63:32] == $past(cfg_wdata_in))
        else $error("prefetchable limit upper word did not reach the window limit");

    AST_IO_HI_WRITE: assert property (
        s_full_write(bfw_pkg::DW_IO_HI) |=> io_lo[31:16] == $past(cfg_wdata_in[15:0]))
        else $error("I/O base upper half did not reach the window base");

    AST_IO_DIRECTION: assert property (
        fwd_req_in && fwd_is_io_in && !fwd_from_primary_in |=> !fwd_io_hit_out [*1])
        else $error("secondary-side I/O transaction was forwarded downstream");

    AST_INCLUSIVE: assert property (
        fwd_req_in && fwd_is_io_in && fwd_from_primary_in && fwd_addr_in == io_hi &&
        io_lo <= io_hi |=> fwd_io_hit_out)
        else $error("I/O window limit address was not treated as inside");

endmodule // bfw_top

/* File: test/bfw_top_tb_top.sv */
/*
 * Self-checking testbench of the forwarding window registers: configuration reads and
 * writes through the dword port, then forwarding queries against the programmed windows.
 * Assumes the design samples its inputs on the rising edge of clk_in; inputs move on the
 * falling edge.
 */
`timescale 1ns/100ps
module bfw_top_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cfg_sel_in = 1'b0;
    logic cfg_wr_in = 1'b0;
    logic [5:0] cfg_dw_addr_in = 6'h00;
    logic [3:0] cfg_be_in = 4'h0;
    logic [31:0] cfg_wdata_in = 32'h00000000;
    logic [31:0] cfg_rdata_out;
    logic cfg_ack_out;
    logic cfg_hit_out;
    logic [15:0] io_base_low_in = 16'h2000;
    logic [31:0] io_limit_in = 32'h00012fff;
    logic fwd_req_in = 1'b0;
    logic [63:0] fwd_addr_in = 64'h0;
    logic fwd_is_io_in = 1'b0;
    logic fwd_from_primary_in = 1'b0;
    logic fwd_valid_out;
    logic fwd_mmio_hit_out;
    logic fwd_pref_hit_out;
    logic fwd_io_hit_out;
    logic fwd_cross_out;
    int errors = 0;
    int checks_done = 0;

    bfw_top bfw_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .cfg_sel_in(cfg_sel_in), .cfg_wr_in(cfg_wr_in),
        .cfg_dw_addr_in(cfg_dw_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out), .cfg_hit_out(cfg_hit_out),
        .io_base_low_in(io_base_low_in), .io_limit_in(io_limit_in), .fwd_req_in(fwd_req_in),
        .fwd_addr_in(fwd_addr_in), .fwd_is_io_in(fwd_is_io_in),
        .fwd_from_primary_in(fwd_from_primary_in), .fwd_valid_out(fwd_valid_out),
        .fwd_mmio_hit_out(fwd_mmio_hit_out), .fwd_pref_hit_out(fwd_pref_hit_out),
        .fwd_io_hit_out(fwd_io_hit_out), .fwd_cross_out(fwd_cross_out)
    );

    always #2.5 clk_in = ~clk_in;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The select falls one cycle after it rose, so accesses are spaced by one idle cycle.
    task automatic cfg_write(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d,
                             input logic h);
        @(negedge clk_in);
        cfg_sel_in = 1'b1;
        cfg_wr_in = 1'b1;
        cfg_dw_addr_in = dw;
        cfg_be_in = be;
        cfg_wdata_in = d;
        @(negedge clk_in);
        cfg_sel_in = 1'b0;
        check({cfg_ack_out, cfg_hit_out, cfg_rdata_out}, {1'b1, h, 32'h00000000});
    endtask

    task automatic cfg_read(input logic [5:0] dw, input logic [31:0] exp, input logic h);
        @(negedge clk_in);
        cfg_sel_in = 1'b1;
        cfg_wr_in = 1'b0;
        cfg_dw_addr_in = dw;
        @(negedge clk_in);
        cfg_sel_in = 1'b0;
        check({cfg_ack_out, cfg_hit_out, cfg_rdata_out}, {1'b1, h, exp});
    endtask

    // Expected hits are given as {mmio, prefetch, io}.
    task automatic fwd(input logic [63:0] a, input logic io, input logic prim,
                       input logic [2:0] exp);
        @(negedge clk_in);
        fwd_req_in = 1'b1;
        fwd_addr_in = a;
        fwd_is_io_in = io;
        fwd_from_primary_in = prim;
        @(negedge clk_in);
        fwd_req_in = 1'b0;
        check({fwd_valid_out, fwd_cross_out, fwd_mmio_hit_out, fwd_pref_hit_out,
               fwd_io_hit_out}, {1'b1, |exp, exp});
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #50000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 8; i <= 12; i++) begin
            cfg_read(6'(i), 32'h00000000, 1'b1);
        end
        cfg_read(6'h07, 32'h00000000, 1'b0);
        cfg_write(6'h08, 4'hf, 32'hffffffff, 1'b1);
        cfg_read(6'h08, 32'hfff0fff0, 1'b1);
        cfg_write(6'h08, 4'h4, 32'h00000000, 1'b1);
        cfg_read(6'h08, 32'hff00fff0, 1'b1);
        cfg_write(6'h08, 4'hf, 32'h0050001f, 1'b1);
        cfg_read(6'h08, 32'h00500010, 1'b1);
        cfg_write(6'h09, 4'hf, 32'h0200010f, 1'b1);
        cfg_read(6'h09, 32'h02000100, 1'b1);
        cfg_write(6'h0a, 4'hf, 32'h00000001, 1'b1);
        cfg_read(6'h0a, 32'h00000001, 1'b1);
        cfg_write(6'h0b, 4'hf, 32'h00000001, 1'b1);
        cfg_read(6'h0b, 32'h00000001, 1'b1);
        cfg_write(6'h0c, 4'hf, 32'hffffffff, 1'b1);
        cfg_read(6'h0c, 32'h0000ffff, 1'b1);
        cfg_write(6'h0c, 4'hf, 32'h00000001, 1'b1);
        cfg_write(6'h0d, 4'hf, 32'hffffffff, 1'b0);
        cfg_read(6'h0d, 32'h00000000, 1'b0);
        // Memory-mapped I/O window runs from 0x0010_0000 to 0x005f_ffff.
        fwd(64'h00000000000fffff, 1'b0, 1'b1, 3'b000);
        fwd(64'h0000000000100000, 1'b0, 1'b1, 3'b100);
        fwd(64'h00000000005fffff, 1'b0, 1'b0, 3'b100);
        fwd(64'h0000000000600000, 1'b0, 1'b1, 3'b000);
        fwd(64'h0000000100100000, 1'b0, 1'b1, 3'b000);
        // Prefetchable window runs from 0x1_0100_0000 to 0x1_020f_ffff.
        fwd(64'h0000000100ffffff, 1'b0, 1'b1, 3'b000);
        fwd(64'h0000000101000000, 1'b0, 1'b1, 3'b010);
        fwd(64'h00000001020fffff, 1'b0, 1'b0, 3'b010);
        fwd(64'h0000000102100000, 1'b0, 1'b1, 3'b000);
        fwd(64'h0000000001000000, 1'b0, 1'b1, 3'b000);
        cfg_write(6'h0a, 4'hf, 32'h00000000, 1'b1);
        cfg_write(6'h0b, 4'hf, 32'h00000000, 1'b1);
        fwd(64'h0000000001000000, 1'b0, 1'b1, 3'b010);
        fwd(64'h0000000101000000, 1'b0, 1'b1, 3'b000);
        // I/O window runs from 0x0001_2000 to 0x0001_2fff.
        fwd(64'h0000000000012000, 1'b1, 1'b1, 3'b001);
        fwd(64'h0000000000011fff, 1'b1, 1'b1, 3'b000);
        fwd(64'h0000000000012fff, 1'b1, 1'b1, 3'b001);
        fwd(64'h0000000000013000, 1'b1, 1'b1, 3'b000);
        fwd(64'h0000000000012000, 1'b1, 1'b0, 3'b000);
        fwd(64'h0000000000012000, 1'b0, 1'b1, 3'b000);
        // A second reset with programmed windows must bring the memory window and I/O base upper registers back to zero.
        @(negedge clk_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        cfg_read(6'h08, 32'h00000000, 1'b1);
        cfg_read(6'h0c, 32'h00000000, 1'b1);
        report_and_stop();
    end
endmodule // bfw_top_tb_top
